// ==== rtl/epbc_mux.sv ====
// address/data ports and bus control port registers with mode-driven pin mux
`timescale 1ns/1ps
module epbc_mux (
    input  wire logic        clk,
    input  wire logic        reset_n,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // mode straps, asynchronous pins
    input  wire logic        specialMode_n,
    input  wire logic        modeSelectB,
    input  wire logic        modeSelectA,
    // core-side controls and bus signals, same clock
    input  wire logic        rebuildControlPortExternally,
    input  wire logic        busClockStretch,
    input  wire logic [15:0] busAddr,
    input  wire logic [15:0] busDataOut,
    input  wire logic        busAddrPhase,
    input  wire logic        busDataDrive,
    input  wire logic        busNarrowHigh,
    output logic      [15:0] busDataIn,
    input  wire logic        dataBusEnableOut,
    input  wire logic        busPhaseClock,
    input  wire logic        lowByteStrobe,
    input  wire logic        readWriteOut,
    input  wire logic        queueStatus1,
    input  wire logic        queueStatus0,
    input  wire logic        clockgenTest,
    input  wire logic        calibrationRef,
    // pins, split into in/out/enable
    input  wire logic [7:0]  highPortIn,
    output logic      [7:0]  highPortOut,
    output logic      [7:0]  highPortOe,
    input  wire logic [7:0]  lowPortIn,
    output logic      [7:0]  lowPortOut,
    output logic      [7:0]  lowPortOe,
    input  wire logic [7:0]  ctlPortIn,
    output logic      [7:0]  ctlPortOut,
    output logic      [7:0]  ctlPortOe,
    output logic      [7:0]  ctlPullUp,
    // external access request for removed registers
    output logic             extAccess,
    output logic             extWrite,
    output logic      [3:0]  extIndex,
    output logic      [7:0]  extWdata,
    output epbc_pkg::epbc_mode_e currentMode
);
    import epbc_pkg::*;

    logic [2:0] strapMeta;        // strap sync first stage
    logic [2:0] strapSync;        // strap sync second stage
    logic [7:0] highMeta;         // pin sync first stages
    logic [7:0] lowMeta;
    logic [7:0] ctlMeta;
    logic [7:0] highSync;         // pin sync second stages
    logic [7:0] lowSync;
    logic [7:0] ctlSync;
    logic       modeValid;        // mode captured after reset
    epbc_mode_e next_mode;        // decoded strap value

    logic [7:0] highData;         // port registers
    logic [7:0] highDir;
    logic [7:0] lowData;
    logic [7:0] lowDir;
    logic [7:0] ctlData;
    logic [7:0] ctlDir;
    logic [7:0] assignReg;        // pin assignment
    logic       assignWritten;    // a write has reached assignment
    logic       pullCtl;          // shared pull-up enable

    logic       phaseValid;       // data phase in progress
    logic       phaseWrite;
    logic       phaseInRange;     // inside the bus-expansion block
    logic [3:0] phaseIndex;
    logic       isReg;            // index names a register
    logic       removed;          // register left the on-chip map
    logic       localHit;         // decoded on chip
    logic       doWrite;
    logic [7:0] readByte;
    logic [7:0] assignMask;       // writable assignment bits now

    logic       isSpecial;        // mode flags
    logic       isSingle;
    logic       isExpanded;
    logic       isNarrow;
    logic       isPeriph;
    logic       isNormExp;
    logic       busPorts;         // address ports serve the bus

    logic [7:0] ctlSel;           // control port alternate functions
    logic [7:0] ctlVal;
    logic [7:0] ctlDrv;
    logic [7:0] highVal;
    logic [7:0] lowVal;
    logic       highDrv;
    logic       lowDrv;

    // strap decode, the unused code falls back to normal single chip
    function automatic epbc_mode_e decodeMode(input logic [2:0] s);
        unique case (s)
            3'h0:    decodeMode = MODE_SPECIAL_SINGLE;
            3'h1:    decodeMode = MODE_SPECIAL_EXP_NARROW;
            3'h2:    decodeMode = MODE_SPECIAL_PERIPH;
            3'h3:    decodeMode = MODE_SPECIAL_EXP_WIDE;
            3'h5:    decodeMode = MODE_NORMAL_EXP_NARROW;
            3'h7:    decodeMode = MODE_NORMAL_EXP_WIDE;
            default: decodeMode = MODE_NORMAL_SINGLE;
        endcase
    endfunction : decodeMode

    // assignment reset value for a mode
    function automatic logic [7:0] assignResetFor(input epbc_mode_e m);
        unique case (m)
            MODE_NORMAL_EXP_NARROW,
            MODE_NORMAL_EXP_WIDE:   assignResetFor = ASSIGN_RST_NORMAL_EXP;
            MODE_SPECIAL_PERIPH:    assignResetFor = ASSIGN_RST_PERIPH;
            MODE_NORMAL_SINGLE:     assignResetFor = ASSIGN_RST_NORMAL_SC;
            MODE_SPECIAL_SINGLE,
            MODE_SPECIAL_EXP_NARROW,
            MODE_SPECIAL_EXP_WIDE:  assignResetFor = ASSIGN_RST_SPECIAL;
        endcase
    endfunction : assignResetFor

    // two-stage synchronisers, free running
    always_ff @(posedge clk) begin
        strapMeta <= {specialMode_n, modeSelectB, modeSelectA};
        strapSync <= strapMeta;
        highMeta  <= highPortIn;
        highSync  <= highMeta;
        lowMeta   <= lowPortIn;
        lowSync   <= lowMeta;
        ctlMeta   <= ctlPortIn;
        ctlSync   <= ctlMeta;
    end

    assign next_mode = decodeMode(strapSync);

    // mode is caught on the first edge after reset release
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            modeValid   <= 1'b0;
            currentMode <= MODE_NORMAL_SINGLE;
        end else if (!modeValid) begin
            modeValid   <= 1'b1;
            currentMode <= next_mode;
        end
    end

    // mode flags
    assign isSpecial  = (currentMode == MODE_SPECIAL_SINGLE) ||
                        (currentMode == MODE_SPECIAL_EXP_NARROW) ||
                        (currentMode == MODE_SPECIAL_PERIPH) ||
                        (currentMode == MODE_SPECIAL_EXP_WIDE);
    assign isSingle   = (currentMode == MODE_SPECIAL_SINGLE) ||
                        (currentMode == MODE_NORMAL_SINGLE);
    assign isPeriph   = (currentMode == MODE_SPECIAL_PERIPH);
    assign isExpanded = !isSingle && !isPeriph;
    assign isNarrow   = (currentMode == MODE_SPECIAL_EXP_NARROW) ||
                        (currentMode == MODE_NORMAL_EXP_NARROW);
    assign isNormExp  = (currentMode == MODE_NORMAL_EXP_NARROW) ||
                        (currentMode == MODE_NORMAL_EXP_WIDE);
    assign busPorts   = isExpanded || isPeriph;

    // address phase capture, held off until the mode is known
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            phaseValid   <= 1'b0;
            phaseWrite   <= 1'b0;
            phaseInRange <= 1'b0;
            phaseIndex   <= 4'h0;
        end else if (hready) begin
            phaseValid   <= hsel && htrans[1] && modeValid && (hsize == 3'h2);
            phaseWrite   <= hwrite;
            phaseInRange <= haddr < EXP_BLOCK_BYTES;
            phaseIndex   <= haddr[5:2];
        end
    end

    assign hreadyout = modeValid;
    assign hresp     = 1'b0;

    // which registers exist and which left the map
    always_comb begin
        isReg   = 1'b0;
        removed = 1'b0;
        unique case (phaseIndex)
            IDX_HIGH_DATA, IDX_LOW_DATA,
            IDX_HIGH_DIR, IDX_LOW_DIR: begin
                isReg   = 1'b1;
                removed = busPorts;
            end
            IDX_CTL_DATA, IDX_CTL_DIR: begin
                isReg   = 1'b1;
                removed = isPeriph || (isExpanded && rebuildControlPortExternally);
            end
            IDX_ASSIGN, IDX_PULL: begin
                isReg   = 1'b1;
            end
            default: begin
                isReg   = 1'b0;
            end
        endcase
        if (isPeriph) begin
            removed = 1'b1;
        end
    end

    assign localHit = phaseValid && phaseInRange && isReg && !removed;
    assign doWrite  = localHit && phaseWrite;

    // removed registers are handed to the external bus
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            extAccess <= 1'b0;
            extWrite  <= 1'b0;
            extIndex  <= 4'h0;
            extWdata  <= 8'h00;
        end else begin
            extAccess <= phaseValid && phaseInRange && removed;
            if (phaseValid && phaseInRange && removed) begin
                extWrite <= phaseWrite;
                extIndex <= phaseIndex;
                extWdata <= hwdata[7:0];
            end
        end
    end

    // address port registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            highData <= PORT_DATA_RST;
            lowData  <= PORT_DATA_RST;
            highDir  <= PORT_DIR_RST;
            lowDir   <= PORT_DIR_RST;
        end else if (doWrite) begin
            if (phaseIndex == IDX_HIGH_DATA) highData <= hwdata[7:0];
            if (phaseIndex == IDX_LOW_DATA)  lowData  <= hwdata[7:0];
            if (phaseIndex == IDX_HIGH_DIR)  highDir  <= hwdata[7:0];
            if (phaseIndex == IDX_LOW_DIR)   lowDir   <= hwdata[7:0];
        end
    end

    // control port registers and pull enable, interrupt pins stay inputs
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctlData <= PORT_DATA_RST;
            ctlDir  <= PORT_DIR_RST;
            pullCtl <= 1'b0;
        end else if (doWrite) begin
            if (phaseIndex == IDX_CTL_DATA) ctlData <= hwdata[7:0];
            if (phaseIndex == IDX_CTL_DIR)  ctlDir  <= hwdata[7:0] & ~INPUT_ONLY_PIN;
            if (phaseIndex == IDX_PULL)     pullCtl <= hwdata[PULL_CTL_BIT];
        end
    end

    // writable assignment bits depend on mode and on the first write
    always_comb begin
        assignMask = 8'h00;
        assignMask[ASSIGN_REF_PIN] = 1'b1;
        if (isSpecial) begin
            if (assignWritten) begin
                assignMask = assignMask | ASSIGN_ONCE_MASK;
                assignMask[ASSIGN_CLKGEN_TEST] = 1'b1;
            end
            if (currentMode == MODE_SPECIAL_SINGLE) begin
                assignMask[ASSIGN_BUSCLK_DIS] = 1'b1;
            end
        end else if (!assignWritten) begin
            assignMask = assignMask | ASSIGN_ONCE_MASK;
            if (currentMode == MODE_NORMAL_SINGLE) begin
                assignMask[ASSIGN_BUSCLK_DIS] = 1'b1;
            end
        end
    end

    // assignment register, loaded with the mode value after reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            assignReg     <= ASSIGN_RST_NORMAL_SC;
            assignWritten <= 1'b0;
        end else if (!modeValid) begin
            assignReg     <= assignResetFor(next_mode);
        end else if (doWrite && phaseIndex == IDX_ASSIGN) begin
            assignReg     <= (assignReg & ~assignMask) | (hwdata[7:0] & assignMask);
            assignWritten <= 1'b1;
        end
    end

    // read mux, inputs read the pin and outputs the latch
    always_comb begin
        readByte = 8'h00;
        unique case (phaseIndex)
            IDX_HIGH_DATA: readByte = (highDir & highData) | (~highDir & highSync);
            IDX_LOW_DATA:  readByte = (lowDir & lowData) | (~lowDir & lowSync);
            IDX_HIGH_DIR:  readByte = highDir;
            IDX_LOW_DIR:   readByte = lowDir;
            IDX_CTL_DATA:  readByte = (ctlDir & ctlData) | (~ctlDir & ctlSync);
            IDX_CTL_DIR:   readByte = ctlDir;
            IDX_ASSIGN:    readByte = assignReg;
            IDX_PULL:      readByte = {7'h00, pullCtl};
            default:       readByte = 8'h00;
        endcase
    end

    assign hrdata = (localHit && !phaseWrite) ? {24'h000000, readByte} : 32'h00000000;

    // control port alternate function selection
    always_comb begin
        ctlSel = 8'h00;
        ctlVal = 8'h00;
        ctlDrv = 8'h00;
        if (isExpanded && !assignReg[ASSIGN_DATA_EN_DIS]) begin
            ctlSel[PIN_DATA_EN] = 1'b1;
            ctlVal[PIN_DATA_EN] = assignReg[ASSIGN_EN_OR_INVCLK] ?
                                  ~busPhaseClock : dataBusEnableOut;
        end else if (assignReg[ASSIGN_REF_PIN]) begin
            ctlSel[PIN_DATA_EN] = 1'b1;
            ctlVal[PIN_DATA_EN] = calibrationRef;
        end
        if (isExpanded && assignReg[ASSIGN_QUEUE_STAT]) begin
            ctlSel[PIN_QUEUE_1] = 1'b1;
            ctlVal[PIN_QUEUE_1] = queueStatus1;
            ctlSel[PIN_QUEUE_0] = 1'b1;
            ctlVal[PIN_QUEUE_0] = queueStatus0;
        end else if (assignReg[ASSIGN_CLKGEN_TEST] && !isSingle && !isNormExp) begin
            ctlSel[PIN_QUEUE_1] = 1'b1;
            ctlVal[PIN_QUEUE_1] = clockgenTest;
        end
        if (!assignReg[ASSIGN_BUSCLK_DIS] && !isPeriph && (!isSingle || !busClockStretch)) begin
            ctlSel[PIN_BUS_CLOCK] = 1'b1;
            ctlVal[PIN_BUS_CLOCK] = busPhaseClock;
        end
        if (assignReg[ASSIGN_LOW_STROBE] && !isSingle &&
            currentMode != MODE_NORMAL_EXP_NARROW) begin
            ctlSel[PIN_STROBE] = 1'b1;
            ctlVal[PIN_STROBE] = lowByteStrobe;
        end
        if (assignReg[ASSIGN_READ_WRITE] && !isSingle) begin
            ctlSel[PIN_RD_WR] = 1'b1;
            ctlVal[PIN_RD_WR] = readWriteOut;
        end
        ctlDrv = ctlSel & ~INPUT_ONLY_PIN;
    end

    // address ports in bus use
    assign highDrv = (isExpanded && busAddrPhase) || busDataDrive;
    assign lowDrv  = isNarrow || highDrv;
    assign highVal = busAddrPhase ? busAddr[15:8] :
                     ((isNarrow && !busNarrowHigh) ? busDataOut[7:0] : busDataOut[15:8]);
    assign lowVal  = (busAddrPhase || isNarrow) ? busAddr[7:0] : busDataOut[7:0];
    assign busDataIn = {highSync, isNarrow ? highSync : lowSync};

    // pull-ups only on listed pins that are inputs now
    assign ctlPullUp = {8{pullCtl}} & PULL_PIN_MASK & ~ctlPortOe;

    epbc_pin_bank highBank (
        .clk       (clk),
        .reset_n   (reset_n),
        .gpioData  (highData),
        .gpioDir   (highDir),
        .altSelect ({8{busPorts}}),
        .altValue  (highVal),
        .altDrive  ({8{highDrv}}),
        .pinOut    (highPortOut),
        .pinOe     (highPortOe)
    );

    epbc_pin_bank lowBank (
        .clk       (clk),
        .reset_n   (reset_n),
        .gpioData  (lowData),
        .gpioDir   (lowDir),
        .altSelect ({8{busPorts}}),
        .altValue  (lowVal),
        .altDrive  ({8{lowDrv}}),
        .pinOut    (lowPortOut),
        .pinOe     (lowPortOe)
    );

    epbc_pin_bank ctlBank (
        .clk       (clk),
        .reset_n   (reset_n),
        .gpioData  (ctlData),
        .gpioDir   (ctlDir),
        .altSelect (ctlSel),
        .altValue  (ctlVal),
        .altDrive  (ctlDrv),
        .pinOut    (ctlPortOut),
        .pinOe     (ctlPortOe)
    );

endmodule : epbc_mux

// ==== rtl/epbc_pin_bank.sv ====
// one eight-pin port: general-purpose or alternate function per pin
`timescale 1ns/1ps
module epbc_pin_bank (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [7:0] gpioData,
    input  wire logic [7:0] gpioDir,
    input  wire logic [7:0] altSelect,
    input  wire logic [7:0] altValue,
    input  wire logic [7:0] altDrive,
    output logic      [7:0] pinOut,
    output logic      [7:0] pinOe
);
    import epbc_pkg::*;

    // alternate function overrides direction, else dir 1 drives data
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pinOut <= PORT_DATA_RST;
            pinOe  <= PORT_DIR_RST;
        end else begin
            pinOut <= (altSelect & altValue) | (~altSelect & gpioData);
            pinOe  <= (altSelect & altDrive) | (~altSelect & gpioDir);
        end
    end

endmodule : epbc_pin_bank

// ==== rtl/epbc_pkg.sv ====
// shared constants and types for the expansion port bus control mux
package epbc_pkg;

    // register indices, byte address is four times the index
    localparam logic [3:0] IDX_HIGH_DATA = 4'h0;  // high address port data
    localparam logic [3:0] IDX_LOW_DATA  = 4'h1;  // low address port data
    localparam logic [3:0] IDX_HIGH_DIR  = 4'h2;  // high address port direction
    localparam logic [3:0] IDX_LOW_DIR   = 4'h3;  // low address port direction
    localparam logic [3:0] IDX_CTL_DATA  = 4'h8;  // bus control port data
    localparam logic [3:0] IDX_CTL_DIR   = 4'h9;  // bus control port direction
    localparam logic [3:0] IDX_ASSIGN    = 4'hA;  // bus control pin assignment
    localparam logic [3:0] IDX_PULL      = 4'hC;  // pull-up control

    // byte span of the bus-expansion block (sixteen word registers)
    localparam int          EXP_BLOCK_REGS  = 16;
    localparam logic [31:0] EXP_BLOCK_BYTES = 32'(EXP_BLOCK_REGS * 4);

    // pin assignment field positions
    localparam int ASSIGN_DATA_EN_DIS  = 7;  // data_enable_pin_disable
    localparam int ASSIGN_CLKGEN_TEST  = 6;  // clockgen_test_output_enable
    localparam int ASSIGN_QUEUE_STAT   = 5;  // queue_status_pin_enable
    localparam int ASSIGN_BUSCLK_DIS   = 4;  // bus_clock_pin_disable
    localparam int ASSIGN_LOW_STROBE   = 3;  // low_strobe_pin_enable
    localparam int ASSIGN_READ_WRITE   = 2;  // read_write_pin_enable
    localparam int ASSIGN_REF_PIN      = 1;  // reference_pin_enable
    localparam int ASSIGN_EN_OR_INVCLK = 0;  // data_enable_or_inv_clock_select

    // pin assignment reset values per mode
    localparam logic [7:0] ASSIGN_RST_NORMAL_EXP = 8'h00;
    localparam logic [7:0] ASSIGN_RST_SPECIAL    = 8'h2C;
    localparam logic [7:0] ASSIGN_RST_PERIPH     = 8'hD0;
    localparam logic [7:0] ASSIGN_RST_NORMAL_SC  = 8'h90;

    // bits that are write once in normal modes, skip-first in special
    localparam logic [7:0] ASSIGN_ONCE_MASK = 8'hAD;

    // bus control port pin positions
    localparam int PIN_DATA_EN   = 7;
    localparam int PIN_QUEUE_1   = 6;
    localparam int PIN_QUEUE_0   = 5;
    localparam int PIN_BUS_CLOCK = 4;
    localparam int PIN_STROBE    = 3;
    localparam int PIN_RD_WR     = 2;

    // pins with pull-ups, and input-only interrupt pins
    localparam logic [7:0] PULL_PIN_MASK  = 8'h8F;
    localparam logic [7:0] INPUT_ONLY_PIN = 8'h03;

    // pull-up control field and reset values of port registers
    localparam int         PULL_CTL_BIT  = 0;
    localparam logic [7:0] PORT_DATA_RST = 8'h00;
    localparam logic [7:0] PORT_DIR_RST  = 8'h00;

    // operating modes taken from the straps
    typedef enum {
        MODE_SPECIAL_SINGLE,
        MODE_SPECIAL_EXP_NARROW,
        MODE_SPECIAL_PERIPH,
        MODE_SPECIAL_EXP_WIDE,
        MODE_NORMAL_SINGLE,
        MODE_NORMAL_EXP_NARROW,
        MODE_NORMAL_EXP_WIDE
    } epbc_mode_e;

endpackage : epbc_pkg

// ==== testbench/epbc_mux_assertions.sv ====
// concurrent checks on the expansion port mux ports
`timescale 1ns/1ps
module epbc_mux_checker (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        busPhaseClock,
    input wire logic [7:0]  lowPortOe,
    input wire logic [7:0]  ctlPortOut,
    input wire logic [7:0]  ctlPortOe,
    input wire logic [7:0]  ctlPullUp,
    input wire logic        extAccess,
    input wire logic [3:0]  extIndex,
    input var epbc_pkg::epbc_mode_e currentMode
);
    import epbc_pkg::*;
    // request accepted at this edge, and mode groups
    wire taken   = hsel && htrans[1] && hready;
    wire expMode = currentMode inside {MODE_SPECIAL_EXP_NARROW, MODE_SPECIAL_EXP_WIDE,
                                       MODE_NORMAL_EXP_NARROW, MODE_NORMAL_EXP_WIDE};
    wire oneChip = currentMode inside {MODE_SPECIAL_SINGLE, MODE_NORMAL_SINGLE};
    wire normExp = currentMode inside {MODE_NORMAL_EXP_NARROW, MODE_NORMAL_EXP_WIDE};
    wire narrow  = currentMode inside {MODE_SPECIAL_EXP_NARROW, MODE_NORMAL_EXP_NARROW};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_irq_input: assert property (ctlPortOe[1:0] == 2'b00)
        else $error("interrupt pin driven");
    a_pull_input: assert property ((ctlPullUp & (ctlPortOe | 8'h70)) == 8'h00)
        else $error("pull-up on output pin");
    a_periph_ext: assert property (taken && haddr < 32'h40 && currentMode == MODE_SPECIAL_PERIPH
        |=> hrdata == 32'h0 ##1 extAccess && extIndex == $past(haddr[5:2], 2))
        else $error("peripheral access kept local");
    a_exp_ext: assert property (taken && haddr < 32'h10 && expMode
        |=> hrdata == 32'h0 ##1 extAccess) else $error("address port register kept local");
    a_ext_cause: assert property (extAccess |-> $past(taken, 2))
        else $error("external cycle without request");
    a_single_local: assert property (taken && oneChip |=> ##1 !extAccess)
        else $error("single chip access went outside");
    a_bus_clock: assert property ($past(currentMode, 3) == currentMode && normExp
        |-> ctlPortOe[4] && ctlPortOut[4] == $past(busPhaseClock)) else $error("bus clock pin");
    a_narrow_low: assert property ($past(currentMode, 3) == currentMode && narrow
        |-> lowPortOe == 8'hFF) else $error("low port not driving address");
endmodule : epbc_mux_checker
bind epbc_mux epbc_mux_checker epbc_mux_checker_inst (.*);

// ==== testbench/epbc_partner.sv ====
// far side: port replacement unit and undriven pin levels
`timescale 1ns/1ps
module epbc_partner (
    input  wire logic       clk,
    input  wire logic [7:0] highPortOut,
    input  wire logic [7:0] highPortOe,
    input  wire logic [7:0] lowPortOut,
    input  wire logic [7:0] lowPortOe,
    input  wire logic [7:0] ctlPortOut,
    input  wire logic [7:0] ctlPortOe,
    input  wire logic [7:0] ctlPullUp,
    input  wire logic       extAccess,
    input  wire logic       extWrite,
    input  wire logic [3:0] extIndex,
    input  wire logic [7:0] extWdata,
    output logic      [7:0] highPortIn,
    output logic      [7:0] lowPortIn,
    output logic      [7:0] ctlPortIn
);
    logic [7:0] noise = 8'h5A;  // floating level, changes every cycle
    logic [7:0] shadow [16];    // registers rebuilt outside the chip
    always @(posedge clk) noise <= {noise[6:0], ~noise[7]};
    always @(posedge clk) if (extAccess && extWrite) shadow[extIndex] <= extWdata;
    // wire level: driver wins, else pull-up or noise
    assign highPortIn = highPortOe & highPortOut | ~highPortOe & noise;
    assign lowPortIn  = lowPortOe & lowPortOut | ~lowPortOe & ~noise;
    assign ctlPortIn  = ctlPortOe & ctlPortOut | ~ctlPortOe & (ctlPullUp | noise);
endmodule : epbc_partner

// ==== testbench/test_epbc_mux.sv ====
// self-checking bench for the expansion port mux
`timescale 1ns/1ps
module test_epbc_mux;
    import epbc_pkg::*;
    logic        clk = 0, reset_n = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 3'h2;  // word transfers only
    logic        specialMode_n = 1, modeSelectB = 0, modeSelectA = 0, busClockStretch;
    logic        rebuildControlPortExternally = 0, busAddrPhase, busDataDrive, busNarrowHigh;
    logic        dataBusEnableOut, busPhaseClock, lowByteStrobe, readWriteOut, queueStatus1;
    logic        queueStatus0, clockgenTest, calibrationRef, extAccess, extWrite;
    logic [15:0] busAddr, busDataOut, busDataIn;
    logic [7:0]  highPortIn, highPortOut, highPortOe, lowPortIn, lowPortOut, lowPortOe;
    logic [7:0]  ctlPortIn, ctlPortOut, ctlPortOe, ctlPullUp, extWdata;
    logic [3:0]  extIndex;
    epbc_mode_e  currentMode;
    int          error_cnt = 0, tests_run = 0;
    assign hready = hreadyout;  // one slave owns the bus ready
    epbc_mux     epbc_mux_inst (.*);
    epbc_partner epbc_partner_inst (.*);
    always #20 clk = ~clk;
    // random core-side traffic every cycle
    always @(posedge clk) {busAddr, busDataOut, busAddrPhase, busDataDrive, busNarrowHigh,
        dataBusEnableOut, busPhaseClock, lowByteStrobe, readWriteOut, queueStatus1, queueStatus0,
        clockgenTest, calibrationRef, busClockStretch} <= 44'({$urandom, $urandom});
    task automatic final_report();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic rdy();  // bounded wait for hready at an edge
        int n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 40);
        if (hready !== 1'b1) begin
            error_cnt++;
            final_report();
        end
    endtask : rdy
    // one single word transfer; a read is compared with e
    task automatic rw(input bit w, input logic [3:0] i, input logic [7:0] d,
                      input logic [7:0] e, input string nm);
        @(posedge clk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 26'h0, i, 2'h0};
        rdy();
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, 24'h0, d};
        rdy();
        if (!w) chk(nm, {24'h0, e}, hrdata);
    endtask : rw
    // bits that one write may change, by mode and first-write state
    function automatic logic [7:0] amask(input int c, input bit first);
        logic [7:0] m;
        m = (c == 0) ? 8'h12 : 8'h02;
        if (c[2] == first) m = m | (c[2] ? ((c inside {4, 6}) ? 8'hBD : 8'hAD) : 8'hED);
        return m;
    endfunction : amask
    initial begin
        logic [7:0] a, d, v;
        bit         sc, px, ex;
        void'($urandom(71));
        for (int c = 0; c < 8; c++) begin
            {specialMode_n, modeSelectB, modeSelectA} <= 3'(c);
            reset_n <= 1'b0;
            rebuildControlPortExternally <= 1'b0;
            repeat (12) @(posedge clk);
            reset_n <= 1'b1;
            repeat (4) @(posedge clk);
            sc = c inside {0, 4, 6};
            px = (c == 2);
            ex = !sc && !px;
            a = c[2] ? (sc ? 8'h90 : 8'h00) : (px ? 8'hD0 : 8'h2C);
            if (c == 4) chk("idle pins", 8'h00, ctlPortOe);
            if (ex) chk("strobe pins", c[2] ? 2'b00 : 2'b11, ctlPortOe[3:2]);
            if (px) chk("test pin", 1'b1, ctlPortOe[6]);
            rw(0, IDX_ASSIGN, 0, px ? 8'h00 : a, "assign reset");
            for (int k = 0; k < 2 && !px; k++) begin
                v = 8'($urandom) | ((k == 0) ? 8'h0C : 8'h00);
                a = a & ~amask(c, k == 0) | v & amask(c, k == 0);
                rw(1, IDX_ASSIGN, v, 0, "");
                rw(0, IDX_ASSIGN, 0, a, "assign write");
            end
            if (ex) chk("strobe enable", {a[3] && c != 5, a[2]}, ctlPortOe[3:2]);
            rw(0, IDX_LOW_DIR, 0, 8'h00, "dir reset");
            rw(0, 4'h5, 0, 8'h00, "unmapped");
            rw(1, IDX_PULL, 8'h01, 0, "");
            d = 8'($urandom);
            rw(1, IDX_CTL_DIR, d, 0, "");
            rw(0, IDX_CTL_DIR, 0, px ? 8'h00 : d & 8'hFC, "ctl dir");
            v = 8'($urandom);
            rw(1, IDX_HIGH_DIR, 8'hFF, 0, "");
            rw(1, IDX_HIGH_DATA, v, 0, "");
            rw(0, IDX_HIGH_DATA, 0, sc ? v : 8'h00, "high data");
            if (sc) chk("high pins", {8'hFF, v}, {highPortOe, highPortOut});
            else chk("rebuilt reg", v, epbc_partner_inst.shadow[0]);
            rebuildControlPortExternally <= 1'b1;
            rw(0, IDX_CTL_DIR, 0, sc ? d & 8'hFC : 8'h00, "rebuild");
            if (sc) chk("bus data in", v, busDataIn[15:8]);
            if (sc) chk("low pins", 8'h00, lowPortOe);
        end
        final_report();
    end
endmodule : test_epbc_mux
